// ### src/acc_consts.svh
// Purpose: Constants of the conversion control block
// Assumes: System clock of 25 MHz
// Notes: Counts derive from times and rates below
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// ----------------------------------------------------------------
// Clocks
// ----------------------------------------------------------------
`define ACC_SYS_CLK_HZ 25000000
`define ACC_INT_CONV_CLK_HZ 6250000
`define ACC_INT_HALF_CYC (`ACC_SYS_CLK_HZ / (2 * `ACC_INT_CONV_CLK_HZ))
`define ACC_EXT_CONV_CLK_MAX_HZ 20000000

// ----------------------------------------------------------------
// Conversion timing in conversion clock half cycles
// ----------------------------------------------------------------
`define ACC_CONV_CYCLES_X2 37
`define ACC_CONV_EDGES 6'd37
`define ACC_PRECHARGE_EDGES 6'd2
`define ACC_GAP_EDGES 6'd2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACC_RST_SPAN 1'b0
`define ACC_RST_PAIRS 3'h0
`define ACC_RST_DAC 10'h000
`define ACC_RST_DIV 3'h0

`endif

// ### src/acc_pkg.sv
// Purpose: Types of the conversion control block
// Assumes: Nothing
// Notes: Constants live in acc_consts.svh
package acc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_CONV,
    ST_GAP
  } acc_state_e;

  typedef logic [2:0] acc_pairs_t;

endpackage

// ### src/acc_tick_if.sv
// Purpose: Carrier between the controller and the clock edge source
// Assumes: One clock domain
// Notes: tick marks one conversion clock edge
`timescale 1ns/1ps
interface acc_tick_if;
  logic ext_sel;
  logic tick;
  modport src (input ext_sel, output tick);
  modport snk (output ext_sel, input tick);
endinterface

// ### src/acc_sync.sv
// Purpose: Two flip-flop synchronisers for pin inputs
// Assumes: Inputs asynchronous to CLK
// Notes: Only the second stage leaves this module
`timescale 1ns/1ps
module acc_sync #(
  parameter int W = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ----------------------------------------------------------------
  // Per bit synchroniser
  // ----------------------------------------------------------------
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta_q[g] <= 1'b0;
        sync_q[g] <= 1'b0;
      end else begin
        meta_q[g] <= d_i[g];
        sync_q[g] <= meta_q[g];
      end
    end
  end

  assign q_o = sync_q;

endmodule

// ### src/acc_conv_tick.sv
// Purpose: Edge pulses of the internal or external conversion clock
// Assumes: External clock level already synchronised
// Notes: Sampling at 25 MHz, fast external clocks alias
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_conv_tick (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_clk_s_i,
  acc_tick_if.src tk
);

  localparam logic [2:0] HALF_LAST = 3'(`ACC_INT_HALF_CYC - 1);

  logic [2:0] div_q, div_d;
  logic ext_prev_q, ext_prev_d;
  logic tick_q, tick_d;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    ext_prev_d = ext_clk_s_i;
    div_d = (div_q == HALF_LAST) ? `ACC_RST_DIV : div_q + 3'h1;
    // Both edges count, a stopped external clock simply gives none
    if (tk.ext_sel) begin
      tick_d = ext_clk_s_i ^ ext_prev_q; // RULE5
    end else begin
      tick_d = (div_q == HALF_LAST); // RULE5
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= `ACC_RST_DIV;
      ext_prev_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      ext_prev_q <= ext_prev_d;
      tick_q <= tick_d;
    end
  end

  assign tk.tick = tick_q;

endmodule

// ### src/acc_ctrl.sv
// Purpose: Conversion control of a three pair sampling converter
// Assumes: Control bits come from logic on CLK_I; strobes and pins are async
// Notes: All outputs registered; conversion clock seen as edge pulses
`timescale 1ns/1ps
`include "acc_consts.svh"

// Rules this block and its host keep
// RULE1: Span from pin in hardware, bits in software
// RULE2: Reference level bit picks 2.5 or 3 V
// RULE3: Latch span pin on busy fall, polarity zero
// RULE4: Precharge sampling capacitors before next acquisition
// RULE5: Internal clock default; software may select external
// RULE6: Conversion lasts 18.5 conversion clock cycles
// RULE7: External clock may stop low between conversions
// RULE8: External clock duty kept within 45 to 55
// RULE9: Hold pair inputs on its strobe rising edge
// RULE10: Software mode uses pair A strobe for all, outside sequential mode
// RULE11: Conversion starts on next conversion clock edge
// RULE12: Host holds strobes high while busy
// RULE13: Strobe fall while busy powers pair down partly
// RULE14: Host keeps strobe skew within 4 ns
// RULE15: Strobes during a conversion are ignored outside sequential mode
// RULE16: Busy rises on strobe, falls with results ready
// RULE17: Host may read right after busy falls
// RULE18: Sequential mode drops busy for one cycle
// RULE19: Busy polarity bit inverts busy output
// RULE20: Ten bit reference code driven to the DAC
// RULE21: Software keeps DAC code at least 204
// RULE22: Internal reference and buffers may power down
// RULE23: Mode select low hardware, high software
// RULE24: Busy active high with polarity bit zero
module acc_ctrl
  import acc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [2:0] PAIR_START_STROBE_I,
  input wire logic MODE_SELECT_INPUT_I,
  input wire logic SHARED_PIN_I,
  input wire logic [2:0] SPAN_BITS_I,
  input wire logic REFERENCE_LEVEL_BIT_I,
  input wire logic BUSY_POLARITY_BIT_I,
  input wire logic CLOCK_SOURCE_BIT_I,
  input wire logic SEQ_MODE_I,
  input wire logic [9:0] DAC_CODE_I,
  input wire logic REF_ENABLE_I,
  input wire logic [2:0] BUF_PD_I,
  output logic BUSY_O,
  output logic [2:0] SPAN_O,
  output logic REF_RANGE_O,
  output logic [9:0] DAC_CODE_O,
  output logic EXT_CLK_SEL_O,
  output logic [2:0] HOLD_O,
  output logic [2:0] CONVERTING_O,
  output logic [2:0] PRECHARGE_O,
  output logic [2:0] PARTIAL_PD_O,
  output logic RESULT_LOAD_O,
  output logic REF_PD_O,
  output logic [2:0] BUF_PD_O
);

  localparam logic [5:0] LAST_EDGE = `ACC_CONV_EDGES - 6'd1;
  localparam logic [5:0] PRE_FIRST = `ACC_CONV_EDGES - `ACC_PRECHARGE_EDGES;
  localparam logic [5:0] GAP_LAST = `ACC_GAP_EDGES - 6'd1;

  // ----------------------------------------------------------------
  // Pin synchronisers and clock edge source
  // ----------------------------------------------------------------
  logic [4:0] pins_s;
  logic [2:0] strobe_s;
  logic sw_mode;
  logic shared_s;

  acc_sync #(.W(5)) u_sync (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .d_i({SHARED_PIN_I, MODE_SELECT_INPUT_I, PAIR_START_STROBE_I}),
    .q_o(pins_s)
  );

  assign strobe_s = pins_s[2:0];
  assign sw_mode = pins_s[3]; // RULE23
  assign shared_s = pins_s[4];

  acc_tick_if tk ();

  acc_conv_tick u_tick (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .ext_clk_s_i(shared_s),
    .tk(tk.src)
  );

  // External clock only in software mode, on the span pin
  assign tk.ext_sel = sw_mode & CLOCK_SOURCE_BIT_I; // RULE5

  // ----------------------------------------------------------------
  // Strobe edges
  // ----------------------------------------------------------------
  logic [2:0] strobe_p_q;
  logic [2:0] rise;
  logic [2:0] fall;
  logic shared_start;
  acc_pairs_t start_set;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      strobe_p_q <= `ACC_RST_PAIRS;
    end else begin
      strobe_p_q <= strobe_s;
    end
  end

  assign rise = strobe_s & ~strobe_p_q;
  assign fall = ~strobe_s & strobe_p_q;
  assign shared_start = sw_mode & ~SEQ_MODE_I;

  always_comb begin
    if (shared_start) begin
      start_set = rise[0] ? 3'h7 : 3'h0; // RULE10
    end else begin
      start_set = rise; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  acc_state_e state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  acc_pairs_t active_q, active_d;
  acc_pairs_t pend_q, pend_d;
  acc_pairs_t pd_q, pd_d;
  logic busy_q, busy_d;
  logic load_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    active_d = active_q;
    pend_d = pend_q;
    pd_d = pd_q;
    busy_d = busy_q;
    load_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (|start_set) begin
          active_d = start_set; // RULE9
          busy_d = 1'b1; // RULE16
          pd_d = pd_q & ~start_set;
          state_d = ST_ARM;
        end
      end
      ST_ARM: begin
        // Late strobes within the skew window join before the first edge
        if (!shared_start) begin
          active_d = active_q | rise; // RULE14
        end
        if (tk.tick) begin
          cnt_d = 6'd1;
          state_d = ST_CONV; // RULE11
        end
      end
      ST_CONV: begin
        if (tk.tick) begin
          if (cnt_q == LAST_EDGE) begin // RULE6
            load_d = 1'b1;
            busy_d = 1'b0; // RULE16
            cnt_d = 6'd0;
            if (SEQ_MODE_I) begin
              state_d = ST_GAP; // RULE18
            end else begin
              active_d = `ACC_RST_PAIRS;
              state_d = ST_IDLE;
            end
          end else begin
            cnt_d = cnt_q + 6'd1;
          end
        end
      end
      ST_GAP: begin
        if (tk.tick) begin
          cnt_d = cnt_q + 6'd1;
          if (cnt_q == GAP_LAST) begin // RULE18
            cnt_d = 6'd0;
            if (|pend_q) begin
              active_d = pend_q;
              pd_d = pd_q & ~pend_q;
              pend_d = `ACC_RST_PAIRS;
              busy_d = 1'b1;
              state_d = ST_ARM;
            end else begin
              active_d = `ACC_RST_PAIRS;
              state_d = ST_IDLE;
            end
          end
        end
      end
    endcase
    // Outside sequential mode new strobes are dropped while busy;
    // strobes in the arm window join instead of queueing twice
    if (SEQ_MODE_I && (state_q == ST_CONV || state_q == ST_GAP)) begin
      pend_d = pend_d | rise;
    end // RULE15
    // Placed last, but a fall counts only while busy_q, which is low at every start clear
    if (busy_q) begin
      pd_d = pd_d | (fall & active_q); // RULE13
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_q <= ST_IDLE;
      cnt_q <= 6'd0;
      active_q <= `ACC_RST_PAIRS;
      pend_q <= `ACC_RST_PAIRS;
      pd_q <= `ACC_RST_PAIRS;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      active_q <= active_d;
      pend_q <= pend_d;
      pd_q <= pd_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Span latch
  // ----------------------------------------------------------------
  logic span_lat_q, span_lat_d;

  always_comb begin
    span_lat_d = span_lat_q;
    if (busy_q && !busy_d && !BUSY_POLARITY_BIT_I) begin
      span_lat_d = shared_s; // RULE3
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      span_lat_q <= `ACC_RST_SPAN;
    end else begin
      span_lat_q <= span_lat_d;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic busy_o_d;
  logic [2:0] span_o_d;
  logic [2:0] conv_o_d;
  logic [2:0] pre_o_d;
  logic in_conv_d;

  always_comb begin
    busy_o_d = busy_d ^ BUSY_POLARITY_BIT_I; // RULE19 RULE24
    if (sw_mode) begin
      span_o_d = SPAN_BITS_I; // RULE1
    end else if (BUSY_POLARITY_BIT_I) begin
      span_o_d = {3{shared_s}}; // RULE1
    end else begin
      span_o_d = {3{span_lat_d}}; // RULE1
    end
    in_conv_d = (state_d == ST_CONV);
    // Precharge in the last edges leaves the next sample defined
    if (in_conv_d && cnt_d >= PRE_FIRST) begin
      pre_o_d = active_d; // RULE4
      conv_o_d = `ACC_RST_PAIRS;
    end else begin
      pre_o_d = `ACC_RST_PAIRS;
      conv_o_d = in_conv_d ? active_d : `ACC_RST_PAIRS;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      BUSY_O <= 1'b0;
      SPAN_O <= `ACC_RST_PAIRS;
      REF_RANGE_O <= 1'b0;
      DAC_CODE_O <= `ACC_RST_DAC;
      EXT_CLK_SEL_O <= 1'b0;
      HOLD_O <= `ACC_RST_PAIRS;
      CONVERTING_O <= `ACC_RST_PAIRS;
      PRECHARGE_O <= `ACC_RST_PAIRS;
      PARTIAL_PD_O <= `ACC_RST_PAIRS;
      RESULT_LOAD_O <= 1'b0;
      REF_PD_O <= 1'b1;
      BUF_PD_O <= `ACC_RST_PAIRS;
    end else begin
      BUSY_O <= busy_o_d;
      SPAN_O <= span_o_d;
      REF_RANGE_O <= REFERENCE_LEVEL_BIT_I; // RULE2
      DAC_CODE_O <= DAC_CODE_I; // RULE20
      EXT_CLK_SEL_O <= tk.ext_sel;
      HOLD_O <= active_d; // RULE9
      CONVERTING_O <= conv_o_d;
      PRECHARGE_O <= pre_o_d;
      PARTIAL_PD_O <= pd_d;
      RESULT_LOAD_O <= load_d;
      REF_PD_O <= ~REF_ENABLE_I; // RULE22
      BUF_PD_O <= BUF_PD_I; // RULE22
    end
  end

endmodule

// ### bench/acc_ctrl_asserts.sv
// Purpose: Port checks of the conversion control block
// Assumes: Polarity and mode steady during conversions
// Notes: Internal conversion clock ticks every 2 CLK
`timescale 1ns/1ps
module acc_ctrl_asserts (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [2:0] PAIR_START_STROBE_I,
  input wire logic MODE_SELECT_INPUT_I,
  input wire logic [2:0] SPAN_BITS_I,
  input wire logic REFERENCE_LEVEL_BIT_I,
  input wire logic BUSY_POLARITY_BIT_I,
  input wire logic CLOCK_SOURCE_BIT_I,
  input wire logic SEQ_MODE_I,
  input wire logic [9:0] DAC_CODE_I,
  input wire logic REF_ENABLE_I,
  input wire logic [2:0] BUF_PD_I,
  input wire logic BUSY_O,
  input wire logic [2:0] SPAN_O,
  input wire logic REF_RANGE_O,
  input wire logic [9:0] DAC_CODE_O,
  input wire logic EXT_CLK_SEL_O,
  input wire logic [2:0] HOLD_O,
  input wire logic [2:0] CONVERTING_O,
  input wire logic [2:0] PRECHARGE_O,
  input wire logic [2:0] PARTIAL_PD_O,
  input wire logic RESULT_LOAD_O,
  input wire logic REF_PD_O,
  input wire logic [2:0] BUF_PD_O
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  logic act;
  assign act = BUSY_O ^ BUSY_POLARITY_BIT_I;

  chk_copy_bits: assert property (!$past(RESET_I) |->
    {REF_RANGE_O, DAC_CODE_O, REF_PD_O, BUF_PD_O} == {$past(REFERENCE_LEVEL_BIT_I),
    $past(DAC_CODE_I), ~$past(REF_ENABLE_I), $past(BUF_PD_I)}) else $error("copy bits wrong");
  chk_ext_select: assert property (EXT_CLK_SEL_O |-> $past(CLOCK_SOURCE_BIT_I) &&
    $past(MODE_SELECT_INPUT_I, 3)) else $error("external clock without source bit");
  chk_busy_start: assert property ($rose(PAIR_START_STROBE_I[0]) && !act &&
    HOLD_O == 3'h0 && !SEQ_MODE_I |-> ##[2:3] (act && HOLD_O[0])) else $error("no busy rise");
  chk_conv_len: assert property ($rose(|CONVERTING_O) && !EXT_CLK_SEL_O |->
    ##[70:74] (RESULT_LOAD_O || |PARTIAL_PD_O)) else $error("conversion length wrong");
  chk_precharge: assert property ($rose(|PRECHARGE_O) && !EXT_CLK_SEL_O |->
    ##[3:5] RESULT_LOAD_O) else $error("precharge not at conversion end");
  chk_end_drop: assert property (RESULT_LOAD_O && !SEQ_MODE_I |->
    !act && HOLD_O == 3'h0 && $past(act)) else $error("busy not dropped with results");
  chk_ignore_new: assert property (|CONVERTING_O && !SEQ_MODE_I |=>
    RESULT_LOAD_O || $stable(HOLD_O)) else $error("strobe taken during conversion");
  chk_partial_pd: assert property ($fell(PAIR_START_STROBE_I[0]) && CONVERTING_O[0] &&
    !PRECHARGE_O[0] |-> ##[2:3] PARTIAL_PD_O[0]) else $error("no partial power-down");
  chk_span_sw: assert property (MODE_SELECT_INPUT_I && $past(MODE_SELECT_INPUT_I, 4) &&
    !$past(RESET_I, 4) |-> SPAN_O == $past(SPAN_BITS_I)) else $error("span not from bits");
  chk_span_hold: assert property (!MODE_SELECT_INPUT_I && !$past(MODE_SELECT_INPUT_I, 4) &&
    !BUSY_POLARITY_BIT_I && !$past(BUSY_POLARITY_BIT_I) && !$past(BUSY_POLARITY_BIT_I, 2) &&
    !RESULT_LOAD_O |-> $stable(SPAN_O)) else $error("span changed outside busy fall");
  chk_seq_gap: assert property (RESULT_LOAD_O && SEQ_MODE_I && !EXT_CLK_SEL_O |->
    !act [*4]) else $error("sequential busy gap too short");

  cov_ext: cover property (EXT_CLK_SEL_O && RESULT_LOAD_O);
  cov_seq: cover property (SEQ_MODE_I && $rose(act));
  cov_ppd: cover property ($rose(PARTIAL_PD_O[0]));
  cov_all: cover property ($rose(HOLD_O == 3'h7));
endmodule

// ### bench/acc_host_model.sv
// Purpose: Host that drives start strobes and the external clock
// Assumes: act_i is busy already corrected for polarity
// Notes: All strobes change together, no skew
`timescale 1ns/1ps
module acc_host_model (
  input wire logic clk_i,
  input wire logic act_i,
  input wire logic ext_run_i,
  output logic [2:0] strobe_o,
  output logic external_conversion_clock_o
);
  // ----------------------------------------------------------------
  // External clock, stopped low outside conversions
  // ----------------------------------------------------------------
  initial begin
    strobe_o = 3'h0;
    external_conversion_clock_o = 1'b0;
  end
  always begin
    #160;
    external_conversion_clock_o = (ext_run_i && strobe_o[0]) ? ~external_conversion_clock_o : 1'b0;
  end

  // ----------------------------------------------------------------
  // Strobe held while busy, unless told to drop early
  // ----------------------------------------------------------------
  task automatic convert(input logic [2:0] mask, input int drop_after, output logic ok);
    int n;
    @(negedge clk_i);
    strobe_o = mask;
    for (n = 0; n < 10 && !act_i; n++) @(negedge clk_i);
    ok = act_i;
    for (n = 0; n < 600 && act_i && n != drop_after; n++) @(negedge clk_i);
    ok = ok && (act_i == (n == drop_after));
    strobe_o = 3'h0;
  endtask
endmodule

// ### bench/tb_acc_ctrl.sv
// Purpose: Self-checking bench of the conversion control block
// Assumes: Inputs change on the falling clock edge
// Notes: Sequential mode run in hardware mode only
`timescale 1ns/1ps
`include "acc_consts.svh"
module tb_acc_ctrl;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk, rst, mode, span_pin, ref_lvl, pol, clk_src, ref_en, external_conversion_clock, ok, shared;
  logic busy, ref_range, ext_sel, ref_pd, seq;
  logic [2:0] strobe, span_bits, buf_pd, span, hold, ppd, buf_pd_o;
  logic [9:0] dac, dac_o;
  int fail_count = 0;
  int n_tests = 0;
  assign shared = (clk_src && mode) ? external_conversion_clock : span_pin;

  acc_ctrl dut_u (.CLK_I(clk), .RESET_I(rst), .PAIR_START_STROBE_I(strobe),
    .MODE_SELECT_INPUT_I(mode), .SHARED_PIN_I(shared), .SPAN_BITS_I(span_bits),
    .REFERENCE_LEVEL_BIT_I(ref_lvl), .BUSY_POLARITY_BIT_I(pol), .CLOCK_SOURCE_BIT_I(clk_src),
    .SEQ_MODE_I(seq), .DAC_CODE_I(dac), .REF_ENABLE_I(ref_en), .BUF_PD_I(buf_pd),
    .BUSY_O(busy), .SPAN_O(span), .REF_RANGE_O(ref_range), .DAC_CODE_O(dac_o),
    .EXT_CLK_SEL_O(ext_sel), .HOLD_O(hold), .CONVERTING_O(), .PRECHARGE_O(),
    .PARTIAL_PD_O(ppd), .RESULT_LOAD_O(), .REF_PD_O(ref_pd), .BUF_PD_O(buf_pd_o));
  acc_host_model host_u (.clk_i(clk), .act_i(busy ^ pol), .ext_run_i(clk_src && mode),
    .strobe_o(strobe), .external_conversion_clock_o(external_conversion_clock));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_static;
    check("ref_pd", ref_pd, 10'h1);
    ref_en = 1'b1; ref_lvl = 1'b1; dac = 10'h0cc; buf_pd = 3'h5; clk_src = 1'b1;
    repeat (3) @(negedge clk);
    check("dac", dac_o, 10'h0cc);
    check("ref", {ref_range, ref_pd, buf_pd_o}, 10'h015);
    check("ext_hw", ext_sel, 10'h0);
    clk_src = 1'b0;
    $display("static done");
  endtask

  task automatic t_hw_conv;
    span_pin = 1'b1;
    repeat (4) @(negedge clk);
    fork
      host_u.convert(3'h1, -1, ok);
      begin
        repeat (20) @(negedge clk);
        check("busy_high", busy, 10'h1);
        host_u.strobe_o[1] = 1'b1;
        repeat (5) @(negedge clk);
        check("hold_b", hold, 10'h1);
      end
    join
    check("hw_done", ok, 10'h1);
    check("span_latch", span, 10'h7);
    span_pin = 1'b0;
    repeat (6) @(negedge clk);
    check("span_kept", span, 10'h7);
    $display("hardware conversion done");
  endtask

  task automatic t_seq;
    int n;
    seq = 1'b1;
    repeat (4) @(negedge clk);
    host_u.strobe_o = 3'h1;
    repeat (20) @(negedge clk);
    host_u.strobe_o = 3'h3;
    for (n = 0; n < 200 && busy; n++) @(negedge clk);
    for (n = 0; n < 20 && !busy; n++) @(negedge clk);
    check("seq_gap", 10'(n), 10'(2 * `ACC_INT_HALF_CYC));
    check("seq_next", hold, 10'h2);
    for (n = 0; n < 200 && busy; n++) @(negedge clk);
    check("seq_done", busy, 10'h0);
    host_u.strobe_o = 3'h0;
    repeat (6) @(negedge clk);
    check("seq_idle", {busy, hold}, 10'h0);
    seq = 1'b0;
    $display("sequential mode done");
  endtask

  task automatic t_sw_all;
    mode = 1'b1; pol = 1'b1; span_bits = 3'h5;
    repeat (6) @(negedge clk);
    check("span_sw", span, 10'h5);
    check("busy_idle", busy, 10'h1);
    fork
      host_u.convert(3'h1, -1, ok);
      begin
        repeat (8) @(negedge clk);
        check("hold_all", hold, 10'h7);
        check("busy_inv", busy, 10'h0);
      end
    join
    check("sw_done", ok, 10'h1);
    $display("software conversion done");
  endtask

  task automatic t_ext;
    clk_src = 1'b1;
    repeat (3) @(negedge clk);
    check("ext_sel", ext_sel, 10'h1);
    host_u.convert(3'h1, -1, ok);
    check("ext_done", ok, 10'h1);
    clk_src = 1'b0;
    $display("external clock done");
  endtask

  task automatic t_ppd;
    mode = 1'b0; span_pin = 1'b1;
    repeat (6) @(negedge clk);
    check("span_live", span, 10'h7);
    pol = 1'b0; span_pin = 1'b0;
    repeat (6) @(negedge clk);
    host_u.convert(3'h1, 30, ok);
    repeat (4) @(negedge clk);
    check("early_drop", ok, 10'h1);
    check("ppd", ppd, 10'h1);
    $display("partial power-down done");
  endtask

  initial begin
    rst = 1'b1; mode = 1'b0; span_pin = 1'b0; ref_lvl = 1'b0; pol = 1'b0; clk_src = 1'b0;
    ref_en = 1'b0; span_bits = 3'h0; buf_pd = 3'h0; dac = 10'h000; seq = 1'b0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_static;
    t_hw_conv;
    t_seq;
    t_sw_all;
    t_ext;
    t_ppd;
    tally_and_finish;
  end

  // Roughly eighteen times the expected run
  initial begin
    #400000;
    fail_count++;
    tally_and_finish;
  end
endmodule

bind acc_ctrl acc_ctrl_asserts chk_u (.*);
